//--- hw/dco_consts.svh
// Constants of the configuration overlay command handler.
// Assumes inclusion by bare name from files under hw/.
// Summary of operation
// - Command B1h selects overlay handling; Features picks the subcommand.
// - Features C0h restore, C1h freeze, C2h identify, C3h set; others reserved.
// - Restore cancels all overlays; identify data returns to full capability.
// - Once frozen, every later overlay subcommand is aborted.
// - Frozen survives soft and hard resets; only power-down clears it.
// - Identify returns 512 bytes by PIO data-in.
// - Reduced capabilities show in normal identify; overlay identify stays full.
// - Set receives overlay data altering identify words 63, 82, 83, 84, 88.
// - Cleared capability bits make the device drop that feature.
// - Overlay ones where full capability is zero are ignored.
// - Failed set aborts; reason, word and bit location go to task file.
// - Protected area present: LBA-changing set or restore aborts, reason 06h word 03h.
// - Disabling enabled security aborts, reason 04h word 07h mask 08h.
// - Word 0 is revision 0002h; word 1 bits 2..0 flag MDMA modes.
// - Word 2 bits 6..0 flag Ultra DMA modes; upper bits reserved.
// - Word 7 carries feature flags at bits 12, 11, 9, 8, 7, 5..0.
// - Word 8 carries serial interface capability flags in bits 4..0.
// - Word 21 bits 13 and 9 flagged; words 22 to 254 reserved.
// - Checksum makes the byte sum of the whole structure zero.
// - Bit location mask: cylinder low bits 15..8, sector number bits 7..0.
// - Reason codes 01h to 08h as defined, FFh for anything else.
`ifndef DCO_CONSTS_SVH
`define DCO_CONSTS_SVH
`define CMD_DCO 8'hb1
`define SUB_RESTORE 8'hc0
`define SUB_FREEZE 8'hc1
`define SUB_IDENT 8'hc2
`define SUB_SET 8'hc3
`define SUB_GROUP 6'h30
`define DCO_REV 16'h0002
`define DCO_SIG 8'ha5
`define W_REV 9'h000
`define W_MDMA 9'h001
`define W_UDMA 9'h002
`define W_LBA0 9'h003
`define W_LBA1 9'h004
`define W_LBA2 9'h005
`define W_FEAT 9'h007
`define W_SATA 9'h008
`define W_EXT 9'h015
`define W_LAST 9'h0ff
`define W_END 9'h100
`define MDMA_MASK 16'h0007
`define UDMA_MASK 16'h007f
`define FEAT_MASK 16'h1bbf
`define SATA_MASK 16'h001f
`define EXT_MASK 16'h2200
`define SEC_BIT 3
`define SEC_MASK 16'h0008
`define RSN_NONE 8'h00
`define RSN_FROZEN 8'h01
`define RSN_SEC_LOCK 8'h02
`define RSN_MODIFIED 8'h03
`define RSN_DISABLE 8'h04
`define RSN_MAX_LOCK 8'h05
`define RSN_PROTECT 8'h06
`define RSN_INVALID 8'h08
`define RSN_OTHER 8'hff
`define LOC_LBA 8'h03
`define LOC_FEAT 8'h07
`define ERR_ABT 8'h04
`define ST_BUSY 8'h80
`define ST_READY 8'h40
`define ST_XFER 8'h48
`define ST_FAIL 8'h41
`endif

//--- hw/dco_pkg.sv
// Types shared by the overlay handler files.
// Assumes nothing beyond a SystemVerilog compiler.
package dco_pkg;
    typedef enum logic [1:0] {idle_st, send_st, recv_st, finish_st} dco_state_type;
    typedef logic [15:0] word_type;
endpackage : dco_pkg

//--- hw/word_if.sv
// Carrier between the handler and its structure word source.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface word_if;
    logic [8:0] idx;
    logic [47:0] max_lba;
    logic [15:0] full;
    modport user (output idx, output max_lba, input full);
    modport source (input idx, input max_lba, output full);
endinterface : word_if
`default_nettype wire

//--- hw/dco_full_word.sv
// Full-capability overlay structure, one word per index.
// Assumes the index is stable while the word is consumed.
`timescale 1ns/10ps
`default_nettype none
`include "dco_consts.svh"
module dco_full_word #(
    parameter logic [15:0] FULL_MDMA = 16'h0007,
    parameter logic [15:0] FULL_UDMA = 16'h007f,
    parameter logic [15:0] FULL_FEAT = 16'h1bbf,
    parameter logic [15:0] FULL_SATA = 16'h001f,
    parameter logic [15:0] FULL_EXT = 16'h2200
)(
    // Word lookup
    word_if.source w
);
    // Reserved bits forced low so they never leak out
    always_comb begin
        w.full = 16'h0000;
        case (w.idx)
            `W_REV: w.full = `DCO_REV;
            `W_MDMA: w.full = FULL_MDMA & `MDMA_MASK;
            `W_UDMA: w.full = FULL_UDMA & `UDMA_MASK;
            // max LBA words, word 6 stays zero
            `W_LBA0: w.full = w.max_lba[15:0];
            `W_LBA1: w.full = w.max_lba[31:16];
            `W_LBA2: w.full = w.max_lba[47:32];
            `W_FEAT: w.full = FULL_FEAT & `FEAT_MASK;
            `W_SATA: w.full = FULL_SATA & `SATA_MASK;
            `W_EXT: w.full = FULL_EXT & `EXT_MASK;
            default: w.full = 16'h0000;
        endcase
    end
endmodule : dco_full_word
`default_nettype wire

//--- hw/dco_handler.sv
// Overlay command handler: decode, freeze, identify, set, restore.
// Assumes task-file strobes and PIO words synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "dco_consts.svh"
module dco_handler
    import dco_pkg::*;
#(
    parameter logic [15:0] FULL_MDMA = 16'h0007,
    parameter logic [15:0] FULL_UDMA = 16'h007f,
    parameter logic [15:0] FULL_FEAT = 16'h1bbf,
    parameter logic [15:0] FULL_SATA = 16'h001f,
    parameter logic [15:0] FULL_EXT = 16'h2200
)(
    // Clock, power-on reset, soft reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic soft_rst,
    // Command issue
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_feature,
    // PIO data-in to host
    output logic pio_in_valid,
    output logic [15:0] pio_in_data,
    input wire logic pio_in_ready,
    // PIO data-out from host
    input wire logic pio_out_valid,
    input wire logic [15:0] pio_out_data,
    output logic pio_out_ready,
    // Drive state seen by the overlay
    input wire logic security_enabled,
    input wire logic security_locked,
    input wire logic max_addr_locked,
    input wire logic hpa_established,
    input wire logic [47:0] native_max_lba,
    // Task-file results
    output logic [7:0] command_status_flags,
    output logic [7:0] command_error_flags,
    output logic [7:0] tf_sector_count,
    output logic [7:0] tf_sector_number,
    output logic [7:0] tf_cyl_low,
    output logic [7:0] tf_cyl_high,
    output logic cmd_done,
    // Effective capabilities for normal identify
    output logic frozen,
    output logic modified,
    output logic [15:0] cap_mdma,
    output logic [15:0] cap_udma,
    output logic [15:0] cap_feat,
    output logic [15:0] cap_sata,
    output logic [15:0] cap_ext,
    output logic [47:0] cap_max_lba
);
    dco_state_type state, next_state;
    logic [8:0] word_idx;
    logic [7:0] sub;
    logic [7:0] sum8;
    logic [7:0] reason, loc_word, pre_reason, pre_word, rx_reason;
    logic [15:0] loc_mask, rx_mask, out_word;
    logic [15:0] stg_mdma, stg_udma, stg_feat, stg_sata, stg_ext;
    logic [47:0] stg_lba;
    logic take, in_load, rx_beat, ok_fin;

    word_if wif();
    assign wif.idx = word_idx;
    assign wif.max_lba = native_max_lba;

    dco_full_word #(
        .FULL_MDMA(FULL_MDMA),
        .FULL_UDMA(FULL_UDMA),
        .FULL_FEAT(FULL_FEAT),
        .FULL_SATA(FULL_SATA),
        .FULL_EXT(FULL_EXT)
    ) u_full (
        .w(wif)
    );

    // opcode filter; other opcodes belong elsewhere
    assign take = (state == idle_st) && cmd_valid && (cmd_code == `CMD_DCO);
    assign in_load = (state == send_st) && (word_idx != `W_END) &&
                     (!pio_in_valid || pio_in_ready);
    assign rx_beat = (state == recv_st) && pio_out_valid;
    assign ok_fin = (state == finish_st) && (reason == `RSN_NONE);
    // signature and checksum in the last word
    assign out_word = (word_idx == `W_LAST) ?
                      {8'h00 - sum8 - `DCO_SIG, `DCO_SIG} : wif.full;

    // Checks made before any data moves
    always_comb begin
        pre_reason = `RSN_NONE;
        pre_word = 8'h00;
        if (cmd_feature[7:2] != `SUB_GROUP) begin
            pre_reason = `RSN_INVALID;
        end else if (frozen) begin
            pre_reason = `RSN_FROZEN;
        end else if (cmd_feature == `SUB_SET || cmd_feature == `SUB_RESTORE) begin
            if (security_locked) begin
                pre_reason = `RSN_SEC_LOCK;
            end else if (max_addr_locked) begin
                pre_reason = `RSN_MAX_LOCK;
            end else if (cmd_feature == `SUB_SET && modified) begin
                pre_reason = `RSN_MODIFIED;
            // restore would move the max LBA
            end else if (cmd_feature == `SUB_RESTORE && hpa_established &&
                         cap_max_lba != native_max_lba) begin
                pre_reason = `RSN_PROTECT;
                pre_word = `LOC_LBA;
            end
        end
    end

    // Checks on each overlay word as it arrives
    always_comb begin
        rx_reason = `RSN_NONE;
        rx_mask = 16'h0000;
        // security may not be switched off
        if (word_idx == `W_FEAT && security_enabled && wif.full[`SEC_BIT] &&
            !pio_out_data[`SEC_BIT]) begin
            rx_reason = `RSN_DISABLE;
            rx_mask = `SEC_MASK;
        // protected area pins the max LBA
        end else if (word_idx == `W_LAST && hpa_established &&
                     stg_lba != cap_max_lba) begin
            rx_reason = `RSN_PROTECT;
        // overlay may only reduce the max LBA
        end else if (word_idx == `W_LAST && stg_lba > native_max_lba) begin
            rx_reason = `RSN_OTHER;
        end
    end

    // Command sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            idle_st: begin
                if (take) begin
                    if (pre_reason != `RSN_NONE) begin
                        next_state = finish_st;
                    end else if (cmd_feature == `SUB_IDENT) begin
                        next_state = send_st;
                    end else if (cmd_feature == `SUB_SET) begin
                        next_state = recv_st;
                    end else begin
                        next_state = finish_st;
                    end
                end
            end
            send_st: begin
                if (word_idx == `W_END && (!pio_in_valid || pio_in_ready)) begin
                    next_state = finish_st;
                end
            end
            recv_st: begin
                if (rx_beat && word_idx == `W_LAST) begin
                    next_state = finish_st;
                end
            end
            finish_st: next_state = idle_st;
        endcase
    end

    // State register; soft reset drops any command in flight
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= idle_st;
        end else if (soft_rst) begin
            state <= idle_st;
        end else begin
            state <= next_state;
        end
    end

    // Subcommand latch and word index
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sub <= 8'h00;
            word_idx <= 9'h000;
        end else if (take) begin
            sub <= cmd_feature;
            word_idx <= 9'h000;
        end else if (in_load || rx_beat) begin
            word_idx <= word_idx + 9'h001;
        end
    end

    // identify words out, one per handshake
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pio_in_valid <= 1'b0;
            pio_in_data <= 16'h0000;
        end else if (soft_rst || state != send_st) begin
            pio_in_valid <= 1'b0;
        end else if (in_load) begin
            pio_in_valid <= 1'b1;
            pio_in_data <= out_word;
        end else if (pio_in_ready) begin
            pio_in_valid <= 1'b0;
        end
    end

    // byte sum of words 0 to 254
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sum8 <= 8'h00;
        end else if (take) begin
            sum8 <= 8'h00;
        end else if (in_load && word_idx != `W_LAST) begin
            sum8 <= sum8 + out_word[7:0] + out_word[15:8];
        end
    end

    // set data accepted only while receiving
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pio_out_ready <= 1'b0;
        end else if (soft_rst) begin
            pio_out_ready <= 1'b0;
        end else begin
            pio_out_ready <= (next_state == recv_st);
        end
    end

    // staging keeps only bits the device really has
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stg_mdma <= 16'h0000;
            stg_udma <= 16'h0000;
            stg_feat <= 16'h0000;
            stg_sata <= 16'h0000;
            stg_ext <= 16'h0000;
            stg_lba <= 48'h0;
        end else if (rx_beat) begin
            case (word_idx)
                `W_MDMA: stg_mdma <= pio_out_data & wif.full;
                `W_UDMA: stg_udma <= pio_out_data & wif.full;
                `W_LBA0: stg_lba[15:0] <= pio_out_data;
                `W_LBA1: stg_lba[31:16] <= pio_out_data;
                `W_LBA2: stg_lba[47:32] <= pio_out_data;
                `W_FEAT: stg_feat <= pio_out_data & wif.full;
                `W_SATA: stg_sata <= pio_out_data & wif.full;
                `W_EXT: stg_ext <= pio_out_data & wif.full;
                default: stg_lba <= stg_lba;
            endcase
        end
    end

    // first violation wins and is kept to the end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reason <= `RSN_NONE;
            loc_word <= 8'h00;
            loc_mask <= 16'h0000;
        end else if (take) begin
            reason <= pre_reason;
            loc_word <= pre_word;
            loc_mask <= 16'h0000;
        end else if (rx_beat && reason == `RSN_NONE && rx_reason != `RSN_NONE) begin
            reason <= rx_reason;
            loc_word <= (rx_mask != 16'h0000) ? `LOC_FEAT : `LOC_LBA;
            loc_mask <= rx_mask;
        end
    end

    // Task-file status and results
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            command_status_flags <= `ST_READY;
            command_error_flags <= 8'h00;
            tf_sector_count <= 8'h00;
            tf_sector_number <= 8'h00;
            tf_cyl_low <= 8'h00;
            tf_cyl_high <= 8'h00;
            cmd_done <= 1'b0;
        end else if (soft_rst) begin
            command_status_flags <= `ST_READY;
            command_error_flags <= 8'h00;
            cmd_done <= 1'b0;
        end else begin
            cmd_done <= (state == finish_st);
            if (take) begin
                command_status_flags <= (next_state == finish_st) ? `ST_BUSY : `ST_XFER;
            end else if (state == finish_st) begin
                command_status_flags <= (reason != `RSN_NONE) ? `ST_FAIL : `ST_READY;
                command_error_flags <= (reason != `RSN_NONE) ? `ERR_ABT : 8'h00;
                tf_sector_count <= reason;
                tf_cyl_high <= loc_word;
                tf_cyl_low <= loc_mask[15:8];
                tf_sector_number <= loc_mask[7:0];
            end
        end
    end

    // freeze cleared by power-on reset only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            frozen <= 1'b0;
        end else if (ok_fin && sub == `SUB_FREEZE) begin
            frozen <= 1'b1;
        end
    end

    // effective capabilities; overlay survives soft reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            modified <= 1'b0;
            cap_mdma <= FULL_MDMA & `MDMA_MASK;
            cap_udma <= FULL_UDMA & `UDMA_MASK;
            cap_feat <= FULL_FEAT & `FEAT_MASK;
            cap_sata <= FULL_SATA & `SATA_MASK;
            cap_ext <= FULL_EXT & `EXT_MASK;
        end else if (ok_fin && sub == `SUB_SET) begin
            modified <= 1'b1;
            cap_mdma <= stg_mdma;
            cap_udma <= stg_udma;
            cap_feat <= stg_feat;
            cap_sata <= stg_sata;
            cap_ext <= stg_ext;
        end else if (ok_fin && sub == `SUB_RESTORE) begin
            modified <= 1'b0;
            cap_mdma <= FULL_MDMA & `MDMA_MASK;
            cap_udma <= FULL_UDMA & `UDMA_MASK;
            cap_feat <= FULL_FEAT & `FEAT_MASK;
            cap_sata <= FULL_SATA & `SATA_MASK;
            cap_ext <= FULL_EXT & `EXT_MASK;
        end
    end

    // max LBA tracks native until an overlay is applied
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_max_lba <= 48'h0;
        end else if (ok_fin && sub == `SUB_SET) begin
            cap_max_lba <= stg_lba;
        end else if (!modified) begin
            cap_max_lba <= native_max_lba;
        end
    end

    // Helper for checks: beats and byte sum seen by the host
    logic [8:0] beat_cnt;
    logic [7:0] tot8;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            beat_cnt <= 9'h000;
            tot8 <= 8'h00;
        end else if (take) begin
            beat_cnt <= 9'h000;
            tot8 <= 8'h00;
        end else if (pio_in_valid && pio_in_ready) begin
            beat_cnt <= beat_cnt + 9'h001;
            tot8 <= tot8 + pio_in_data[7:0] + pio_in_data[15:8];
        end
    end

    AST_OPCODE_ONLY: assert property (@(posedge mclk) disable iff (!arst_n)
        (state == idle_st && cmd_valid && cmd_code != `CMD_DCO) |=> state == idle_st)
        else $error("foreign opcode started the handler");
    AST_RESERVED_SUB: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (take && cmd_feature[7:2] != `SUB_GROUP) |-> ##2 (command_status_flags == `ST_FAIL
        && command_error_flags == `ERR_ABT && tf_sector_count == `RSN_INVALID && beat_cnt == 9'h000))
        else $error("reserved subcommand not aborted");
    AST_FROZEN_ABORT: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (take && frozen && cmd_feature[7:2] == `SUB_GROUP) |-> ##2
        (tf_sector_count == `RSN_FROZEN && command_status_flags == `ST_FAIL))
        else $error("frozen subcommand not aborted");
    AST_FROZEN_STICKY: assert property (@(posedge mclk) disable iff (!arst_n)
        frozen |=> frozen)
        else $error("frozen condition lost");
    AST_IDENT_LEN: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (ok_fin && sub == `SUB_IDENT) |-> beat_cnt == `W_END)
        else $error("identify did not move 256 words");
    AST_SIGNATURE: assert property (@(posedge mclk) disable iff (!arst_n)
        (pio_in_valid && state == send_st && word_idx == `W_END) |-> pio_in_data[7:0] == `DCO_SIG)
        else $error("last word lacks signature");
    AST_CHECKSUM: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (ok_fin && sub == `SUB_IDENT) |-> tot8 == 8'h00)
        else $error("structure byte sum not zero");
    AST_SEC_REPORT: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (state == finish_st && reason == `RSN_DISABLE) |=> (tf_cyl_high == `LOC_FEAT
        && tf_cyl_low == 8'h00 && tf_sector_number == 8'h08 && tf_sector_count == 8'h04))
        else $error("security abort misreported");
    AST_PROT_REPORT: assert property (@(posedge mclk) disable iff (!arst_n || soft_rst)
        (state == finish_st && reason == `RSN_PROTECT) |=> (tf_cyl_high == `LOC_LBA
        && tf_sector_count == 8'h06 && !modified == !$past(modified)))
        else $error("protected area abort misreported");
    AST_SET_APPLY: assert property (@(posedge mclk) disable iff (!arst_n)
        (ok_fin && sub == `SUB_SET) |=> (modified && cap_feat == $past(stg_feat)
        && cap_max_lba == $past(stg_lba)))
        else $error("accepted overlay not applied");
    AST_IGNORE_ONES: assert property (@(posedge mclk) disable iff (!arst_n)
        (cap_feat & ~(FULL_FEAT & `FEAT_MASK)) == 16'h0000)
        else $error("capability beyond full set");
    AST_RESTORE: assert property (@(posedge mclk) disable iff (!arst_n)
        (ok_fin && sub == `SUB_RESTORE) |=> (!modified && cap_udma == (FULL_UDMA & `UDMA_MASK)))
        else $error("restore left overlay in place");
endmodule : dco_handler
`default_nettype wire

//--- bench/host_link.sv
// Host model: feeds set overlay words and takes identify words.
// Assumes the bench fills tx and holds go high around a data command.
`timescale 1ns/10ps
`default_nettype none
module host_link import dco_pkg::*; (
    // Clock, reset, control, PIO pair
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic pio_in_valid,
    input wire word_type pio_in_data,
    output logic pio_in_ready,
    output logic pio_out_valid,
    output word_type pio_out_data,
    input wire logic pio_out_ready
);
    word_type rx [256];
    word_type tx [256];
    int rx_n;
    int tx_n;
    // Slow mode drops pio_in_ready every other cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_n <= 0;
            tx_n <= 0;
            pio_in_ready <= 1'b0;
        end else begin
            pio_in_ready <= go && !(slow && pio_in_ready);
            rx_n <= !go ? 0 : rx_n + int'(pio_in_valid && pio_in_ready);
            tx_n <= !go ? 0 : tx_n + int'(pio_out_valid && pio_out_ready);
            if (pio_in_valid && pio_in_ready) rx[rx_n[7:0]] <= pio_in_data;
        end
    end
    // Word held until taken; idle line shows its inverse
    assign pio_out_valid = go && tx_n < 256;
    assign pio_out_data = pio_out_valid ? tx[tx_n[7:0]] : ~tx[tx_n[7:0]];
endmodule : host_link
`default_nettype wire

//--- bench/config_overlay_command_handler_tb_top.sv
// Bench for the overlay handler, one task per command.
// Assumes host_link on the PIO side; drive state set by the bench.
`timescale 1ns/10ps
`default_nettype none
module config_overlay_command_handler_tb_top import dco_pkg::*;;
    logic mclk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0, cmd_valid = 1'b0, go = 1'b0;
    logic slow = 1'b1, sec_en = 1'b0, hpa = 1'b0;
    logic [7:0] cmd_feature = 8'h00, cmd_code = 8'hb1;
    logic pio_in_valid, pio_in_ready, pio_out_valid, pio_out_ready, cmd_done, frozen, modified;
    word_type pio_in_data, pio_out_data, cap_mdma, cap_feat, cap_udma, cap_sata, cap_ext;
    logic [7:0] st, er, sc, sn, cl, ch;
    logic [47:0] cap_max_lba;
    int err_total = 0, samples_checked = 0, cycles = 0;
    int widx [7] = '{0, 1, 2, 7, 8, 21, 22};
    word_type wexp [7] = '{16'h0002, 16'h0007, 16'h007f, 16'h1bbf, 16'h001f, 16'h2200, 16'h0000};
    localparam logic [47:0] NATIVE = 48'h000012345678;
    localparam logic [47:0] SMALL = 48'h000012340000;
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    dco_handler dco_handler_i (.mclk, .arst_n, .soft_rst, .cmd_valid, .cmd_code,
        .cmd_feature, .pio_in_valid, .pio_in_data, .pio_in_ready, .pio_out_valid,
        .pio_out_data, .pio_out_ready, .security_enabled(sec_en), .security_locked(1'b0),
        .max_addr_locked(1'b0), .hpa_established(hpa), .native_max_lba(NATIVE),
        .command_status_flags(st), .command_error_flags(er), .tf_sector_count(sc),
        .tf_sector_number(sn), .tf_cyl_low(cl), .tf_cyl_high(ch), .cmd_done, .frozen,
        .modified, .cap_mdma, .cap_udma, .cap_feat, .cap_sata, .cap_ext, .cap_max_lba);
    host_link host_link_i (.mclk, .arst_n, .go, .slow, .pio_in_valid, .pio_in_data,
        .pio_in_ready, .pio_out_valid, .pio_out_data, .pio_out_ready);
    task check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // opcode B1h, bounded wait for done; go dropped for one edge to rewind the host
    task issue(input logic [7:0] f, input logic g);
        int n;
        n = 0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_feature <= f;
        go <= 1'b0;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        go <= g;
        while (cmd_done !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(48'(n < 3000), 48'h1);
    endtask : issue
    // Foreign opcode with a freeze feature must leave everything alone
    task foreign;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= 8'hec;
        cmd_feature <= 8'hc1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code <= 8'hb1;
        repeat (3) @(posedge mclk);
        #1;
        check(48'({st, cmd_done, frozen}), 48'h104);
    endtask : foreign
    task result(input logic [7:0] s, input logic [7:0] r, input logic [7:0] w, input word_type m);
        check(48'(st), 48'(s));
        check(48'(er), (s == 8'h41) ? 48'h4 : 48'h0);
        check(48'({sc, ch, cl, sn}), 48'({r, w, m}));
    endtask : result
    task identify;
        logic [7:0] s;
        s = 8'h00;
        issue(8'hc2, 1'b1);
        result(8'h40, 8'h00, 8'h00, 16'h0000);
        check(48'(host_link_i.rx_n), 48'd256);
        for (int i = 0; i < 7; i++) check(48'(host_link_i.rx[widx[i]]), 48'(wexp[i]));
        for (int i = 0; i < 256; i++) s = s + host_link_i.rx[i][7:0] + host_link_i.rx[i][15:8];
        check(48'(s), 48'h0);
        check(48'(host_link_i.rx[255][7:0]), 48'ha5);
    endtask : identify
    // Overlay image at full capability except max LBA words 3 to 5, taken from lba, and word 7, which has security bit 3 cleared
    task load(input logic [47:0] lba);
        for (int i = 0; i < 256; i++) host_link_i.tx[i] = 16'h0000;
        for (int i = 0; i < 6; i++) host_link_i.tx[widx[i]] = wexp[i];
        {host_link_i.tx[5], host_link_i.tx[4], host_link_i.tx[3]} = lba;
        host_link_i.tx[7] = 16'h1bb7;
    endtask : load
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            issue(8'h00 + 8'(i * 196), 1'b1);
            result(8'h41, 8'h08, 8'h00, 16'h0000);
            check(48'(host_link_i.rx_n), 48'h0);
        end
        identify();
        load(NATIVE);
        @(posedge mclk);
        sec_en <= 1'b1;
        issue(8'hc3, 1'b1);
        result(8'h41, 8'h04, 8'h07, 16'h0008);
        load(SMALL);
        host_link_i.tx[1] = 16'hfffb;
        host_link_i.tx[21] = 16'h0200;
        @(posedge mclk);
        sec_en <= 1'b0;
        foreign();
        issue(8'hc3, 1'b1);
        result(8'h40, 8'h00, 8'h00, 16'h0000);
        check({cap_mdma, cap_feat, cap_ext}, 48'h00031bb70200);
        check(48'({cap_udma, cap_sata}), 48'h007f001f);
        check(cap_max_lba, SMALL);
        issue(8'hc3, 1'b0);
        check(48'(sc), 48'h03);
        identify();
        @(posedge mclk);
        hpa <= 1'b1;
        issue(8'hc0, 1'b0);
        result(8'h41, 8'h06, 8'h03, 16'h0000);
        @(posedge mclk);
        hpa <= 1'b0;
        issue(8'hc0, 1'b0);
        @(posedge mclk);
        #1;
        check(48'({st, 7'h0, modified, cap_mdma, cap_ext}), 48'h400000072200);
        check(cap_max_lba, NATIVE);
        issue(8'hc1, 1'b0);
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            issue(8'hc0 + 8'(i), 1'b0);
            check(48'({st, sc, 7'h0, frozen}), 48'h410101);
        end
        @(posedge mclk);
        arst_n <= 1'b0;
        @(posedge mclk);
        arst_n <= 1'b1;
        identify();
        end_of_test();
    end
    // Ceiling against a hung handshake
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            end_of_test();
        end
    end
endmodule : config_overlay_command_handler_tb_top
`default_nettype wire
